// ### rtl/sfdp_jedec_param_table.sv
// parameter-read serial responder with ahb-lite control registers
`timescale 1ns/100ps
module sfdp_jedec_param_table
    import sfdp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe_n
);

    ser_state_e  state_q;
    logic [2:0]  bit_q;
    logic [1:0]  abyte_q;
    logic [7:0]  in_q;
    logic [7:0]  in_byte;
    logic [23:0] addr_q;
    logic [7:0]  sh_q;
    logic        so_q;
    logic        so_oe_n_q;
    logic [7:0]  rom_data;
    logic        rise;
    logic        fall;
    logic        enable_q;
    logic        reject_q;
    logic [7:0]  last_cmd_q;
    logic [15:0] count_q;
    ahb_req_s    req_q;
    logic        rd_wait_q;
    logic [31:0] hrdata_q;
    logic        addr_ok;

    sclk_edge u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sclk    (sclk),
        .rise    (rise),
        .fall    (fall)
    );

    param_rom u_rom (
        .hclk    (hclk),
        .hresetn (hresetn),
        .addr    (addr_q),
        .rdata_q (rom_data)
    );

    // byte as it stands after this rising edge
    assign in_byte = {in_q[6:0], si};

    // framing sequence: opcode, address, dummy, data until select rises
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_CMD;
            bit_q   <= 3'h0;
            abyte_q <= 2'h0;
            in_q    <= 8'h00;
        end else if (cs_n) begin
            state_q <= ST_CMD;
            bit_q   <= 3'h0;
            abyte_q <= 2'h0;
        end else if (rise) begin
            in_q  <= in_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == BIT_LAST) begin
                case (state_q)
                    ST_CMD: begin
                        // a disabled block or foreign opcode stays silent to the frame end
                        if (enable_q && in_byte == CMD_PARAM_READ) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_ADDR: begin
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == ADDR_BYTES_LAST) begin
                            state_q <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: state_q <= ST_DATA;
                    ST_DATA:  state_q <= ST_DATA;
                    ST_IGNORE: state_q <= ST_IGNORE;
                    default:  state_q <= ST_IGNORE;
                endcase
            end
        end
    end

    // address shift in, then advance one byte per byte sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 24'h000000;
        end else if (!cs_n && rise && state_q == ST_ADDR && bit_q == BIT_LAST) begin
            addr_q <= {addr_q[15:0], in_byte};
        end else if (!cs_n && fall && state_q == ST_DATA && bit_q == 3'h0) begin
            addr_q <= addr_q + 24'h000001;
        end
    end

    // output shifter, msb first, changed on falling edges; rom has a full
    // serial phase to settle after each address step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            so_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (!cs_n && fall && state_q == ST_DATA) begin
            if (bit_q == 3'h0) begin
                so_q <= rom_data[7];
                sh_q <= {rom_data[6:0], 1'b0};
            end else begin
                so_q <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    // output enable low only while a data phase drives the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            so_oe_n_q <= 1'b1;
        end else if (cs_n) begin
            so_oe_n_q <= 1'b1;
        end else if (fall && state_q == ST_DATA) begin
            so_oe_n_q <= 1'b0;
        end
    end

    assign so      = so_q;
    assign so_oe_n = so_oe_n_q;

    // ahb address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.valid <= hsel && (htrans == HTRANS_NONSEQ);
            req_q.write <= hwrite;
            req_q.addr  <= haddr[3:0];
        end
    end

    // reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite;
        end
    end

    assign addr_ok = (req_q.addr == REG_CTRL_OFS) || (req_q.addr == REG_STATUS_OFS)
                     || (req_q.addr == REG_COUNT_OFS);

    // read mux; unmapped words read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_wait_q) begin
            hrdata_q <= 32'h00000000;
            case (req_q.addr)
                REG_CTRL_OFS:   hrdata_q[CTRL_EN_BIT] <= enable_q;
                REG_STATUS_OFS: begin
                    hrdata_q[STAT_BUSY_BIT] <= ~cs_n;
                    hrdata_q[STAT_DATA_BIT] <= (state_q == ST_DATA);
                    hrdata_q[STAT_REJ_BIT]  <= reject_q;
                    hrdata_q[15:8]          <= last_cmd_q;
                end
                REG_COUNT_OFS:  hrdata_q[15:0] <= count_q;
                default:        hrdata_q <= 32'h00000000;
            endcase
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = ~rd_wait_q;
    assign hresp     = HRESP_OKAY;

    // enable bit; writes reach this register and the status reject clear, never the table
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= CTRL_EN_RESET;
        end else if (req_q.valid && req_q.write && addr_ok
                     && req_q.addr == REG_CTRL_OFS) begin
            enable_q <= hwdata[CTRL_EN_BIT];
        end
    end

    // last opcode seen, and sticky flag for refused opcodes; set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_cmd_q <= 8'h00;
            reject_q   <= 1'b0;
        end else begin
            if (!cs_n && rise && state_q == ST_CMD && bit_q == BIT_LAST) begin
                last_cmd_q <= in_byte;
            end
            if (!cs_n && rise && state_q == ST_CMD && bit_q == BIT_LAST
                && !(enable_q && in_byte == CMD_PARAM_READ)) begin
                reject_q <= 1'b1;
            end else if (req_q.valid && req_q.write && req_q.addr == REG_STATUS_OFS
                         && hwdata[STAT_REJ_BIT]) begin
                reject_q <= 1'b0;
            end
        end
    end

    // count of reads that reached their data phase, wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 16'h0000;
        end else if (!cs_n && rise && state_q == ST_DUMMY && bit_q == BIT_LAST) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // checks

    sequence s_dummy_done;
        !cs_n && rise && state_q == ST_DUMMY && bit_q == BIT_LAST;
    endsequence

    sequence s_enter_data;
        state_q == ST_DATA && bit_q == 3'h0;
    endsequence

    a_dummy_to_data: assert property (@(posedge hclk) disable iff (!hresetn)
        s_dummy_done |=> s_enter_data)
        else $error("data phase not entered after dummy byte");

    a_cmd_accept: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cs_n && rise && state_q == ST_CMD && bit_q == BIT_LAST
         && in_byte == CMD_PARAM_READ && enable_q) |=> state_q == ST_ADDR)
        else $error("param read opcode not accepted");

    a_release_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        cs_n |=> (so_oe_n && state_q == ST_CMD))
        else $error("output still driven after select rose");

    a_hdr_pointer: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == HDR_PTR0_ADDR |=> rom_data == 8'h30)
        else $error("header pointer wrong");

    a_byte30_value: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == OFS_B30 |=> (rom_data == 8'he5 && rom_data[7:5] == 3'b111))
        else $error("byte 30h wrong");

    a_byte31_value: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == OFS_B31 |=> rom_data == 8'h20)
        else $error("byte 31h wrong");

    a_byte32_value: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == OFS_B32 |=> rom_data == 8'hb0)
        else $error("byte 32h wrong");

    a_byte38_value: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == OFS_B38 |=> rom_data == 8'h44)
        else $error("byte 38h wrong");

    a_byte39_value: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_q == OFS_B39 |=> rom_data == 8'heb)
        else $error("byte 39h wrong");

    a_tail_values: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_q == OFS_B3A |=> rom_data == 8'h00)
        and (addr_q == OFS_B3B |=> rom_data == 8'hff))
        else $error("byte 3Ah or 3Bh wrong");

    a_density_unused: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_q == OFS_B37 |=> rom_data == 8'h00)
        and (addr_q == OFS_B33 |=> rom_data == 8'hff))
        else $error("density or unused byte wrong");

    a_table_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_q == $past(addr_q)) |=> $stable(rom_data))
        else $error("table byte changed under a fixed address");

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // the pin is only driven while table bytes are being shifted
    a_oe_in_data: assert property (@(posedge hclk) disable iff (!hresetn)
        !so_oe_n |-> state_q == ST_DATA)
        else $error("output driven outside the data phase");

    // each byte loaded into the shifter moves the table address on by exactly one
    a_addr_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cs_n && fall && state_q == ST_DATA && bit_q == 3'h0)
        |=> addr_q == $past(addr_q) + 24'h000001)
        else $error("table address did not step by one");

    // an opcode refused while disabled raises the sticky flag even against a clear
    a_reject_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (!cs_n && rise && state_q == ST_CMD && bit_q == BIT_LAST && !enable_q)
        |=> reject_q)
        else $error("refused opcode not flagged");

endmodule

// ### rtl/sfdp_pkg.sv
// constants, types and table contents of the parameter-read table block
package sfdp_pkg;

    // serial command framing
    localparam logic [7:0]  CMD_PARAM_READ   = 8'h5a;
    localparam logic [1:0]  ADDR_BYTES_LAST  = 2'h2;    // three address bytes, index 0..2
    localparam logic [2:0]  BIT_LAST         = 3'h7;

    // header entries that locate the basic table
    localparam logic [23:0] HDR_LEN_ADDR     = 24'h00000b;
    localparam logic [23:0] HDR_PTR0_ADDR    = 24'h00000c;
    localparam logic [23:0] HDR_PTR1_ADDR    = 24'h00000d;
    localparam logic [23:0] HDR_PTR2_ADDR    = 24'h00000e;
    localparam logic [7:0]  HDR_LEN_DWORDS   = 8'h09;
    localparam logic [23:0] PARAM_TABLE_POINTER = 24'h000030;

    // first table byte fields
    localparam logic [1:0]  ERASE_4K_OK      = 2'b01;
    localparam logic        WRITE_GRAN_64    = 1'b1;
    localparam logic        WREN_VOL_REQ     = 1'b0;
    localparam logic        WREN_VOL_OPSEL   = 1'b0;
    localparam logic [2:0]  UNUSED_THREE     = 3'b111;

    // third table byte fields
    localparam logic        FR_112           = 1'b0;
    localparam logic [1:0]  ADDR_3BYTE_ONLY  = 2'b00;
    localparam logic        DTR_SUPPORT      = 1'b0;
    localparam logic        FR_122           = 1'b1;
    localparam logic        FR_144           = 1'b1;
    localparam logic        FR_114           = 1'b0;
    localparam logic        UNUSED_ONE       = 1'b1;

    // fast read 1-4-4 timing fields
    localparam logic [4:0]  FR144_DUMMY      = 5'b00100;
    localparam logic [2:0]  FR144_MODE_BITS  = 3'b010;

    localparam logic [7:0]  BYTE_UNUSED      = 8'hff;
    localparam logic [31:0] DENSITY_BITS_M1  = 32'h00ffffff;

    // byte offsets inside the parameter space
    localparam logic [23:0] OFS_B30 = 24'h000030;
    localparam logic [23:0] OFS_B31 = 24'h000031;
    localparam logic [23:0] OFS_B32 = 24'h000032;
    localparam logic [23:0] OFS_B33 = 24'h000033;
    localparam logic [23:0] OFS_B34 = 24'h000034;
    localparam logic [23:0] OFS_B35 = 24'h000035;
    localparam logic [23:0] OFS_B36 = 24'h000036;
    localparam logic [23:0] OFS_B37 = 24'h000037;
    localparam logic [23:0] OFS_B38 = 24'h000038;
    localparam logic [23:0] OFS_B39 = 24'h000039;
    localparam logic [23:0] OFS_B3A = 24'h00003a;
    localparam logic [23:0] OFS_B3B = 24'h00003b;

    // assembled byte values
    localparam logic [7:0]  VAL_B30 = {UNUSED_THREE, WREN_VOL_OPSEL, WREN_VOL_REQ,
                                       WRITE_GRAN_64, ERASE_4K_OK};
    localparam logic [7:0]  VAL_B31 = 8'h20;
    localparam logic [7:0]  VAL_B32 = {UNUSED_ONE, FR_114, FR_144, FR_122, DTR_SUPPORT,
                                       ADDR_3BYTE_ONLY, FR_112};
    localparam logic [7:0]  VAL_B38 = {FR144_MODE_BITS, FR144_DUMMY};
    localparam logic [7:0]  VAL_B39 = 8'heb;
    localparam logic [7:0]  VAL_B3A = 8'h00;
    localparam logic [7:0]  VAL_B3B = 8'hff;

    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  REG_STATUS_OFS   = 4'h4;
    localparam logic [3:0]  REG_COUNT_OFS    = 4'h8;
    localparam int          CTRL_EN_BIT      = 0;
    localparam logic        CTRL_EN_RESET    = 1'b1;
    localparam int          STAT_BUSY_BIT    = 0;
    localparam int          STAT_DATA_BIT    = 1;
    localparam int          STAT_REJ_BIT     = 2;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;
    localparam logic [1:0]  HRESP_OKAY       = 2'b00;

    // serial state, gray along cmd, addr, dummy, data
    typedef enum logic [2:0] {
        ST_CMD    = 3'b000,
        ST_ADDR   = 3'b001,
        ST_DUMMY  = 3'b011,
        ST_DATA   = 3'b010,
        ST_IGNORE = 3'b110
    } ser_state_e;

    // captured address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] addr;
    } ahb_req_s;

endpackage

// ### rtl/param_rom.sv
// fixed parameter table with registered read data
`timescale 1ns/100ps
module param_rom
    import sfdp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [23:0] addr,
    output logic      [7:0]  rdata_q
);

    logic [7:0] rdata_d;

    // constant lookup, no write path exists into it
    always_comb begin
        rdata_d = BYTE_UNUSED;
        case (addr)
            HDR_LEN_ADDR:  rdata_d = HDR_LEN_DWORDS;
            HDR_PTR0_ADDR: rdata_d = PARAM_TABLE_POINTER[7:0];
            HDR_PTR1_ADDR: rdata_d = PARAM_TABLE_POINTER[15:8];
            HDR_PTR2_ADDR: rdata_d = PARAM_TABLE_POINTER[23:16];
            OFS_B30:       rdata_d = VAL_B30;
            OFS_B31:       rdata_d = VAL_B31;
            OFS_B32:       rdata_d = VAL_B32;
            OFS_B33:       rdata_d = BYTE_UNUSED;
            OFS_B34:       rdata_d = DENSITY_BITS_M1[7:0];
            OFS_B35:       rdata_d = DENSITY_BITS_M1[15:8];
            OFS_B36:       rdata_d = DENSITY_BITS_M1[23:16];
            OFS_B37:       rdata_d = DENSITY_BITS_M1[31:24];
            OFS_B38:       rdata_d = VAL_B38;
            OFS_B39:       rdata_d = VAL_B39;
            OFS_B3A:       rdata_d = VAL_B3A;
            OFS_B3B:       rdata_d = VAL_B3B;
            default:       rdata_d = BYTE_UNUSED;
        endcase
    end

    // read register; only the address steers it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= BYTE_UNUSED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule

// ### rtl/sclk_edge.sv
// serial clock edge finder on the system clock
`timescale 1ns/100ps
module sclk_edge (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic sclk,
    output logic      rise,
    output logic      fall
);

    logic sclk_q;

    // previous level; pin is already synchronous so no second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    assign rise = sclk & ~sclk_q;
    assign fall = ~sclk & sclk_q;

endmodule

// ### sim/host_reader.sv
// host-side model that issues parameter reads on the serial pins
`timescale 1ns/100ps
module host_reader (
    input  wire logic hclk,
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic [7:0] rx_q [0:15];    // bytes captured in the last frame
    logic       oe_seen;        // so_oe_n went low somewhere in the last frame
    logic       so_line;        // line as the host sees it; no pull, so undriven reads inverted

    // an undriven line must not hand the host the last bit the responder left behind
    assign so_line = (so_oe_n === 1'b0) ? so : ~so;

    // mode 0: clock idles low, select idles high
    initial begin
        cs_n    = 1'b1;
        sclk    = 1'b0;
        si      = 1'b0;
        oe_seen = 1'b0;
    end

    // four hclk per phase keeps clear of the three-cycle minimum of the responder
    task automatic half;
        repeat (4) @(posedge hclk);
    endtask

    // one frame: opcode, address, dummy byte, then nbytes shifted out msb first
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nbytes);
        logic [39:0] hdr;
        hdr = {op, a, 8'h00};
        oe_seen = 1'b0;
        @(posedge hclk);
        cs_n <= 1'b0;
        for (int i = 39; i >= 0; i--) begin
            si <= hdr[i];
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
        for (int b = 0; b < nbytes; b++) begin
            for (int i = 7; i >= 0; i--) begin
                si <= ~si;  // don't care now; toggling avoids a stale level
                half();
                rx_q[b][i] = so_line;
                if (so_oe_n === 1'b0) oe_seen = 1'b1;
                sclk <= 1'b1;
                half();
                sclk <= 1'b0;
            end
        end
        half();
        cs_n <= 1'b1;
        si <= ~si;
        repeat (3) @(posedge hclk);     // gap between frames
    endtask
endmodule

// ### sim/sfdp_jedec_param_table_bench.sv
// self-checking bench for the parameter-read table block
`timescale 1ns/100ps
module sfdp_jedec_param_table_bench;
    import sfdp_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [1:0]  hresp;
    logic        cs_n;
    logic        sclk;
    logic        si;
    logic        so;
    logic        so_oe_n;
    int          fails;
    int          n_compared;
    int          exp_cnt;
    logic [31:0] rd;
    // rows: address in the upper bits, expected byte in the low byte
    logic [31:0] rows [0:15] = '{32'h00000b09, 32'h00000c30, 32'h00000d00, 32'h00000e00,
        32'h000030e5, 32'h00003120, 32'h000032b0, 32'h000033ff, 32'h000034ff, 32'h000035ff,
        32'h000036ff, 32'h00003700, 32'h00003844, 32'h000039eb, 32'h00003a00, 32'h00003bff};

    sfdp_jedec_param_table u_sfdp_jedec_param_table (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n));

    host_reader u_host_reader (
        .hclk(hclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n));

    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hready is looked at on the falling edge, half a cycle before the rising edge, where it has settled
    task automatic wait_rdy;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check(hresp, 32'h0);    // response is always okay
    endtask

    // one byte read at a, plus end-of-frame release of the data line
    task automatic read1(input logic [23:0] a, input logic [7:0] d);
        u_host_reader.frame(CMD_PARAM_READ, a, 1);
        exp_cnt++;
        check(u_host_reader.rx_q[0], d);
        check(so_oe_n, 1'b1);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fails = 0;
        n_compared = 0;
        exp_cnt = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        check(rd, 32'h1);   // enable comes out of reset set
        for (int i = 0; i < 16; i++) read1(rows[i][31:8], rows[i][7:0]);
        // burst across the whole table: address steps one per byte
        u_host_reader.frame(CMD_PARAM_READ, 24'h000030, 12);
        exp_cnt++;
        for (int k = 0; k < 12; k++) check(u_host_reader.rx_q[k], rows[4+k][7:0]);
        // wrong opcode is ignored, flagged and the flag clears on write-one
        u_host_reader.frame(8'h03, 24'h000030, 1);
        check(u_host_reader.oe_seen, 1'b0);
        ahb(1'b0, 32'h4, 32'h0);
        check(rd & 32'h0000ff07, 32'h00000304);
        ahb(1'b1, 32'h4, 32'h4);
        ahb(1'b0, 32'h4, 32'h0);
        check(rd & 32'h4, 32'h0);
        // count is read-only and counts only frames that reached data
        ahb(1'b1, 32'h8, 32'h0000abcd);
        ahb(1'b0, 32'h8, 32'h0);
        check(rd & 32'hffff, exp_cnt);
        // disabled responder stays silent
        ahb(1'b1, 32'h0, 32'h0);
        u_host_reader.frame(CMD_PARAM_READ, 24'h000030, 1);
        check(u_host_reader.oe_seen, 1'b0);
        ahb(1'b1, 32'h0, 32'h1);
        ahb(1'b0, 32'hc, 32'h0);
        check(rd, 32'h0);   // unmapped offset reads zero
        // table bytes 30h to 33h unchanged after all writes and refused traffic
        for (int i = 4; i < 8; i++) read1(rows[i][31:8], rows[i][7:0]);
        // status while a read is in its data phase: busy, data and the opcode show
        fork
            u_host_reader.frame(CMD_PARAM_READ, 24'h000030, 4);
            begin
                repeat (400) @(posedge hclk);
                ahb(1'b0, 32'h4, 32'h0);
                check(rd & 32'h0000ff03, 32'h00005a03);
            end
        join
        exp_cnt++;
        for (int k = 0; k < 4; k++) check(u_host_reader.rx_q[k], rows[4+k][7:0]);
        ahb(1'b0, 32'h8, 32'h0);
        check(rd & 32'hffff, exp_cnt);
        // mid-run reset with the block disabled: outputs idle, enable comes back set
        ahb(1'b1, 32'h0, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check(hreadyout, 1'b1);
        check(hrdata, 32'h0);
        check(so_oe_n, 1'b1);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0);
        check(rd, 32'h1);
        ahb(1'b0, 32'h8, 32'h0);
        check(rd & 32'hffff, 32'h0);
        read1(rows[4][31:8], rows[4][7:0]);
        end_of_test();
    end

    // watchdog, about five and a half times the expected run length
    initial begin
        repeat (60000) @(posedge hclk);
        fails++;
        end_of_test();
    end
endmodule
